// ---- mmd_pkg.sv ----
// Package: address map, region codes and flash/RAM control constants
package mmd_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// Region bounds
	localparam logic [15:0] PERIPH_LO = 16'h0000;
	localparam logic [15:0] PERIPH_HI = 16'h0FFF;
	localparam logic [15:0] BOOT_LO = 16'h1000;
	localparam logic [15:0] BOOT_HI = 16'h17FF;
	localparam logic [15:0] INFO_LO = 16'h1800;
	localparam logic [15:0] INFO_HI = 16'h19FF;
	localparam logic [15:0] INFO_A_LO = 16'h1980;
	localparam logic [15:0] DESC_LO = 16'h1A00;
	localparam logic [15:0] DESC_HI = 16'h1A7F;
	localparam logic [15:0] SPARE_LO = 16'h1A80;
	localparam logic [15:0] SPARE_HI = 16'h1AFF;
	localparam logic [15:0] RAM0_LO = 16'h1C00;
	localparam logic [15:0] RAM0_HI = 16'h23FF;
	localparam logic [15:0] RAM1_LO = 16'h2400;
	localparam logic [15:0] RAM1_HI = 16'h2BFF;
	localparam logic [15:0] MAIN_LO = 16'h8000;
	localparam logic [15:0] MAIN_HI = 16'hFFFF;
	localparam logic [15:0] VECT_LO = 16'hFF80;
	// Segment index field positions
	localparam int MAIN_SEG_LSB = 9;
	localparam int INFO_SEG_LSB = 7;
	localparam int BOOT_SEG_LSB = 9;
	// Value returned on a vacant read
	localparam logic [15:0] VACANT_READ = 16'h3FFF;
	localparam int RAM_SECTORS = 2;
	localparam logic [1:0] RAM_EN_RST = 2'h3;
	typedef enum logic [3:0] {
		MMD_VACANT, MMD_PERIPH, MMD_BOOT, MMD_INFO, MMD_DESC, MMD_SPARE,
		MMD_RAM0, MMD_RAM1, MMD_MAIN
	} mmd_region_e;
	typedef enum logic [1:0] {MMD_SZ_BYTE, MMD_SZ_WORD, MMD_SZ_LONG} mmd_size_e;
	typedef enum logic [1:0] {MMD_ER_NONE, MMD_ER_SEG, MMD_ER_MAIN, MMD_ER_ALL} mmd_erase_e;
endpackage

// ---- mmd_dec_if.sv ----
// Interface: decoded access information between decoder and controller
interface mmd_dec_if;
	import mmd_pkg::*;
	logic [15:0] addr;
	mmd_region_e region;
	logic [5:0] main_seg;
	logic [1:0] info_seg;
	logic [1:0] boot_seg;
	logic vector_hit;
	modport dec(input addr, output region, main_seg, info_seg, boot_seg, vector_hit);
	modport ctl(output addr, input region, main_seg, info_seg, boot_seg, vector_hit);
endinterface

// ---- mmd_region_dec.sv ----
// Combinational address-to-region decoder
module mmd_region_dec (
	mmd_dec_if.dec dif
);
	import mmd_pkg::*;

	// Region lookup used for every decode
	function automatic mmd_region_e region_of(input logic [15:0] a);
		if (a <= PERIPH_HI) return MMD_PERIPH; // [RQ9]
		else if (a >= BOOT_LO && a <= BOOT_HI) return MMD_BOOT; // [RQ8]
		else if (a >= INFO_LO && a <= INFO_HI) return MMD_INFO; // [RQ7]
		else if (a >= DESC_LO && a <= DESC_HI) return MMD_DESC; // [RQ6]
		else if (a >= SPARE_LO && a <= SPARE_HI) return MMD_SPARE; // [RQ5]
		else if (a >= RAM0_LO && a <= RAM0_HI) return MMD_RAM0; // [RQ4]
		else if (a >= RAM1_LO && a <= RAM1_HI) return MMD_RAM1; // [RQ4]
		else if (a >= MAIN_LO) return MMD_MAIN; // [RQ2]
		else return MMD_VACANT; // [RQ1]
	endfunction

	// Region and segment fields
	always_comb begin
		dif.region = region_of(dif.addr);
		dif.main_seg = dif.addr[14:MAIN_SEG_LSB];
		dif.info_seg = dif.addr[8:INFO_SEG_LSB];
		dif.boot_seg = dif.addr[10:BOOT_SEG_LSB];
		dif.vector_hit = (dif.addr >= VECT_LO);
	end
endmodule

// ---- mmd_memory_map.sv ----
// Memory map decoder with vacant access detection and flash/RAM control
//
// Contract
// [RQ1] Addresses outside all regions are vacant; accessing one pulses the vacant interrupt.
// [RQ2] Main flash decodes as one 32KB bank 0x8000 to 0xFFFF.
// [RQ3] Addresses 0xFF80 to 0xFFFF are the vector area inside main flash.
// [RQ4] RAM decodes as sector 0 at 0x1C00-0x23FF, sector 1 at 0x2400-0x2BFF.
// [RQ5] 0x1A80 to 0x1AFF decodes as valid memory, never vacant.
// [RQ6] Device descriptor decodes as 0x1A00 to 0x1A7F.
// [RQ7] Information flash is four 128-byte segments, A top, D bottom.
// [RQ8] Boot loader flash is four 512-byte segments numbered upward from 0x1000.
// [RQ9] Peripherals occupy 0x0000 to 0x0FFF, reachable by every access.
// [RQ10] Flash accepts byte, word and long-word writes.
// [RQ11] Main erase segments are 512 bytes; info segments 128 bytes.
// [RQ12] Flash supports whole main erase and single main segment erase.
// [RQ13] Info segments erase singly or together with main in a group erase.
// [RQ14] Info segment A has its own lock blocking writes and erases.
// [RQ15] Each RAM sector can be disabled and powered down, losing contents.
// [RQ16] Idle RAM sectors drop to retention automatically, keeping contents.
// [RQ17] Vacant reads return a fixed value; vacant writes are discarded.
module mmd_memory_map (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic clk_en_in,
	input wire logic acc_valid_in,
	input wire logic acc_write_in,
	input wire logic [15:0] acc_addr_in,
	input wire mmd_pkg::mmd_size_e acc_size_in,
	input wire logic [15:0] acc_rdata_in,
	input wire logic erase_req_in,
	input wire mmd_pkg::mmd_erase_e erase_mode_in,
	input wire logic info_a_lock_in,
	input wire logic [1:0] ram_enable_in,
	output logic [15:0] acc_rdata_out,
	output logic acc_done_out,
	output mmd_pkg::mmd_region_e region_out,
	output logic [5:0] main_seg_out,
	output logic [1:0] info_seg_out,
	output logic [1:0] boot_seg_out,
	output logic vector_hit_out,
	output logic periph_sel_out,
	output logic flash_wr_out,
	output mmd_pkg::mmd_size_e flash_wr_size_out,
	output logic flash_blocked_out,
	output logic erase_go_out,
	output mmd_pkg::mmd_erase_e erase_kind_out,
	output logic erase_info_a_out,
	output logic [1:0] ram_sel_out,
	output logic [1:0] ram_power_out,
	output logic [1:0] ram_retain_out,
	output logic vacant_irq_out
);
	import mmd_pkg::*;

	mmd_dec_if dif ();

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign dif.addr = acc_addr_in;
	mmd_region_dec u_dec (
		.dif(dif)
	);

	logic is_flash;
	logic is_vacant;
	logic a_locked;
	// Access classification
	always_comb begin
		is_flash = (dif.region == MMD_MAIN) || (dif.region == MMD_INFO) ||
			(dif.region == MMD_BOOT); // [RQ2] [RQ7] [RQ8]
		is_vacant = (dif.region == MMD_VACANT); // [RQ1] [RQ5]
		a_locked = info_a_lock_in && (dif.region == MMD_INFO) &&
			(dif.info_seg == 2'h3); // [RQ14]
	end

	// ----------------------------------------
	// Access response state
	// ----------------------------------------
	logic [15:0] rdata, next_rdata;
	logic done, next_done;
	mmd_region_e region, next_region;
	logic [5:0] mseg, next_mseg;
	logic [1:0] iseg, next_iseg;
	logic [1:0] bseg, next_bseg;
	logic vhit, next_vhit;
	logic psel, next_psel;
	logic fwr, next_fwr;
	mmd_size_e fsize, next_fsize;
	logic fblk, next_fblk;
	logic virq, next_virq;
	logic [1:0] rsel, next_rsel;

	// Next response values
	always_comb begin
		next_done = acc_valid_in;
		next_region = acc_valid_in ? dif.region : region;
		next_mseg = dif.main_seg; // [RQ11]
		next_iseg = dif.info_seg; // [RQ11]
		next_bseg = dif.boot_seg;
		next_vhit = acc_valid_in && dif.vector_hit; // [RQ3]
		next_psel = acc_valid_in && (dif.region == MMD_PERIPH); // [RQ9]
		next_fwr = acc_valid_in && acc_write_in && is_flash && !a_locked; // [RQ10]
		next_fsize = acc_valid_in ? acc_size_in : fsize; // [RQ10]
		next_fblk = acc_valid_in && acc_write_in && a_locked; // [RQ14]
		next_virq = acc_valid_in && is_vacant; // [RQ1]
		next_rdata = (acc_valid_in && is_vacant) ? VACANT_READ : acc_rdata_in; // [RQ17]
		next_rsel[0] = acc_valid_in && (dif.region == MMD_RAM0) && ram_enable_in[0]; // [RQ4]
		next_rsel[1] = acc_valid_in && (dif.region == MMD_RAM1) && ram_enable_in[1]; // [RQ4]
	end

	// Register response
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			done <= 1'b0;
			region <= MMD_VACANT;
			mseg <= 6'h00;
			iseg <= 2'h0;
			bseg <= 2'h0;
			vhit <= 1'b0;
			psel <= 1'b0;
			fwr <= 1'b0;
			fsize <= MMD_SZ_BYTE;
			fblk <= 1'b0;
			virq <= 1'b0;
			rdata <= 16'h0000;
			rsel <= 2'h0;
		end else if (clk_en_in) begin
			done <= next_done;
			region <= next_region;
			mseg <= next_mseg;
			iseg <= next_iseg;
			bseg <= next_bseg;
			vhit <= next_vhit;
			psel <= next_psel;
			fwr <= next_fwr;
			fsize <= next_fsize;
			fblk <= next_fblk;
			virq <= next_virq;
			rdata <= next_rdata;
			rsel <= next_rsel;
		end
	end

	// ----------------------------------------
	// Erase control
	// ----------------------------------------
	logic ego, next_ego;
	mmd_erase_e ekind, next_ekind;
	logic ea, next_ea;
	// Erase request qualification
	always_comb begin
		next_ego = 1'b0;
		next_ekind = ekind;
		next_ea = 1'b0;
		if (erase_req_in) begin
			case (erase_mode_in)
				MMD_ER_SEG: begin
					// Single segment: main or info, not boot or locked A
					next_ego = (dif.region == MMD_MAIN) ||
						((dif.region == MMD_INFO) && !a_locked); // [RQ12] [RQ13] [RQ14]
					next_ekind = MMD_ER_SEG;
				end
				MMD_ER_MAIN: begin
					next_ego = 1'b1; // [RQ12]
					next_ekind = MMD_ER_MAIN;
				end
				MMD_ER_ALL: begin
					next_ego = 1'b1; // [RQ13]
					next_ekind = MMD_ER_ALL;
					next_ea = !info_a_lock_in; // [RQ14]
				end
				default: begin
					next_ego = 1'b0;
				end
			endcase
		end
	end

	// Register erase command
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ego <= 1'b0;
			ekind <= MMD_ER_NONE;
			ea <= 1'b0;
		end else if (clk_en_in) begin
			ego <= next_ego;
			ekind <= next_ekind;
			ea <= next_ea;
		end
	end

	// ----------------------------------------
	// RAM sector power
	// ----------------------------------------
	logic [1:0] rpow, next_rpow;
	logic [1:0] rret, next_rret;
	// Power and retention per sector
	always_comb begin
		next_rpow = ram_enable_in; // [RQ15]
		next_rret = ram_enable_in & ~next_rsel; // [RQ16]
	end

	// Register sector power state
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rpow <= RAM_EN_RST;
			rret <= RAM_EN_RST;
		end else if (clk_en_in) begin
			rpow <= next_rpow;
			rret <= next_rret;
		end
	end

	// Output drive
	assign acc_rdata_out = rdata;
	assign acc_done_out = done;
	assign region_out = region;
	assign main_seg_out = mseg;
	assign info_seg_out = iseg;
	assign boot_seg_out = bseg;
	assign vector_hit_out = vhit;
	assign periph_sel_out = psel;
	assign flash_wr_out = fwr;
	assign flash_wr_size_out = fsize;
	assign flash_blocked_out = fblk;
	assign erase_go_out = ego;
	assign erase_kind_out = ekind;
	assign erase_info_a_out = ea;
	assign ram_sel_out = rsel;
	assign ram_power_out = rpow;
	assign ram_retain_out = rret;
	assign vacant_irq_out = virq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	vacant_irq_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ1]
		clk_en_in && acc_valid_in && (acc_addr_in inside {[16'h2C00:16'h7FFF]})
		|=> vacant_irq_out && acc_rdata_out == VACANT_READ)
		else $error("vacant access not flagged");
	spare_valid_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ5]
		clk_en_in && acc_valid_in && acc_addr_in[15:7] == 9'h035 |=> !vacant_irq_out)
		else $error("spare region flagged vacant");
	main_bank_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ2]
		clk_en_in && acc_valid_in && acc_addr_in[15] |=> region_out == MMD_MAIN)
		else $error("main flash not decoded");
	vector_area_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ3]
		clk_en_in && acc_valid_in |=> vector_hit_out == ($past(acc_addr_in) >= 16'hFF80))
		else $error("vector area decode wrong");
	ram_sector_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ4]
		clk_en_in && acc_valid_in && acc_addr_in == 16'h2400 && ram_enable_in[1]
		|=> ram_sel_out == 2'h2 && region_out == MMD_RAM1)
		else $error("ram sector 1 decode wrong");
	desc_area_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ6]
		clk_en_in && acc_valid_in && acc_addr_in[15:7] == 9'h034 |=> region_out == MMD_DESC)
		else $error("descriptor decode wrong");
	info_lock_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ14]
		clk_en_in && acc_valid_in && acc_write_in && info_a_lock_in &&
		acc_addr_in[15:7] == 9'h033 |=> !flash_wr_out && flash_blocked_out)
		else $error("locked segment A written");
	periph_sel_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ9]
		clk_en_in && acc_valid_in && acc_addr_in[15:12] == 4'h0 |=> periph_sel_out)
		else $error("peripheral select missing");
	ram_retain_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ16]
		clk_en_in && !acc_valid_in |=> ram_retain_out == ram_power_out)
		else $error("idle sector not retained");
	ram_off_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // [RQ15]
		clk_en_in && !ram_enable_in[0] |=> !ram_power_out[0] && !ram_sel_out[0])
		else $error("disabled sector still powered");
endmodule

// ---- mmd_cpu_mem_model.sv ----
// Partner model: memory behind the decoder, answering CPU reads in the same cycle
module mmd_cpu_mem_model (
	input wire logic core_clk_in,
	input wire logic acc_valid_in,
	input wire logic [15:0] acc_addr_in,
	output logic [15:0] rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] idle_pat = 16'h1234;
	// Idle pattern flips every cycle so stale data never passes for a read
	always_ff @(posedge core_clk_in) begin
		idle_pat <= ~idle_pat;
	end
	// Read data is a known function of the address while an access is presented
	assign rdata_out = acc_valid_in ? (acc_addr_in ^ 16'h5A5A) : idle_pat;
endmodule

// ---- memory_map_decoder_vacant_access_tb.sv ----
// Testbench: region decode, vacant handling, flash write/erase and RAM sector control
module memory_map_decoder_vacant_access_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import mmd_pkg::*;
	logic core_clk_in = 0, arst_n_in = 0, clk_en_in = 1, acc_valid_in = 0, acc_write_in = 0;
	logic erase_req_in = 0, info_a_lock_in = 0;
	logic [15:0] acc_addr_in = 16'h0000, acc_rdata_in, acc_rdata_out;
	logic [1:0] ram_enable_in = 2'h3, info_seg_out, boot_seg_out, ram_sel_out;
	logic [1:0] ram_power_out, ram_retain_out;
	mmd_size_e acc_size_in = MMD_SZ_WORD, flash_wr_size_out;
	mmd_erase_e erase_mode_in = MMD_ER_NONE, erase_kind_out;
	mmd_region_e region_out;
	logic [5:0] main_seg_out;
	logic acc_done_out, vector_hit_out, periph_sel_out, flash_wr_out, flash_blocked_out;
	logic erase_go_out, erase_info_a_out, vacant_irq_out;
	int bad_count = 0;
	int samples_checked = 0;
	// ----------------------------------------------------------------
	// Design and partner
	// ----------------------------------------------------------------
	mmd_memory_map dut (.core_clk_in, .arst_n_in, .clk_en_in, .acc_valid_in, .acc_write_in,
		.acc_addr_in, .acc_size_in, .acc_rdata_in, .erase_req_in, .erase_mode_in,
		.info_a_lock_in, .ram_enable_in, .acc_rdata_out, .acc_done_out, .region_out,
		.main_seg_out, .info_seg_out, .boot_seg_out, .vector_hit_out, .periph_sel_out,
		.flash_wr_out, .flash_wr_size_out, .flash_blocked_out, .erase_go_out,
		.erase_kind_out, .erase_info_a_out, .ram_sel_out, .ram_power_out, .ram_retain_out,
		.vacant_irq_out);
	mmd_cpu_mem_model mem (.core_clk_in, .acc_valid_in, .acc_addr_in, .rdata_out(acc_rdata_in));
	// Clock, 5 ns period
	initial begin
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// One access taken at the next edge, answer sampled just after it
	task automatic access(input logic [15:0] a, input logic w, input mmd_size_e s);
		@(posedge core_clk_in);
		#1;
		acc_valid_in = 1;
		acc_write_in = w;
		acc_addr_in = a;
		acc_size_in = s;
		@(posedge core_clk_in);
		#1;
		acc_valid_in = 0;
		check(acc_done_out, 1);
	endtask
	task automatic erase(input mmd_erase_e m, input logic [15:0] a, input logic go, input logic ia);
		@(posedge core_clk_in);
		#1;
		erase_req_in = 1;
		erase_mode_in = m;
		acc_addr_in = a;
		@(posedge core_clk_in);
		#1;
		erase_req_in = 0;
		check(erase_go_out, go);
		check(erase_info_a_out, ia);
		if (go) check(16'(erase_kind_out), 16'(m));
	endtask
	// Expected region from the documented map
	function automatic mmd_region_e exp_reg(input logic [15:0] a);
		if (a <= 16'h0FFF) return MMD_PERIPH;
		if (a >= 16'h1000 && a <= 16'h17FF) return MMD_BOOT;
		if (a >= 16'h1800 && a <= 16'h19FF) return MMD_INFO;
		if (a >= 16'h1A00 && a <= 16'h1A7F) return MMD_DESC;
		if (a >= 16'h1A80 && a <= 16'h1AFF) return MMD_SPARE;
		if (a >= 16'h1C00 && a <= 16'h23FF) return MMD_RAM0;
		if (a >= 16'h2400 && a <= 16'h2BFF) return MMD_RAM1;
		if (a >= 16'h8000) return MMD_MAIN;
		return MMD_VACANT;
	endfunction
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_decode();
		logic [15:0] tbl[22] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h17FF, 16'h1800, 16'h19FF,
			16'h1A00, 16'h1A7F, 16'h1A80, 16'h1AFF, 16'h1B00, 16'h1BFF, 16'h1C00, 16'h23FF,
			16'h2400, 16'h2BFF, 16'h2C00, 16'h7FFF, 16'h8000, 16'hFF7F, 16'hFF80, 16'hFFFF};
		mmd_region_e e;
		foreach (tbl[i]) begin
			e = exp_reg(tbl[i]);
			access(tbl[i], 0, MMD_SZ_WORD);
			check(16'(region_out), 16'(e));
			check(vacant_irq_out, e == MMD_VACANT);
			check(acc_rdata_out, e == MMD_VACANT ? 16'h3FFF : tbl[i] ^ 16'h5A5A);
			check(periph_sel_out, e == MMD_PERIPH);
			check(vector_hit_out, tbl[i] >= 16'hFF80);
			check(ram_sel_out, {e == MMD_RAM1, e == MMD_RAM0});
			check(ram_retain_out, {e != MMD_RAM1, e != MMD_RAM0});
			if (e == MMD_MAIN) check(main_seg_out, tbl[i][14:9]);
			if (e == MMD_INFO) check(info_seg_out, tbl[i][8:7]);
			if (e == MMD_BOOT) check(boot_seg_out, tbl[i][10:9]);
		end
	endtask
	task automatic test_writes();
		mmd_size_e sz[3] = '{MMD_SZ_BYTE, MMD_SZ_WORD, MMD_SZ_LONG};
		foreach (sz[i]) begin
			access(16'h8000, 1, sz[i]);
			check(flash_wr_out, 1);
			check(16'(flash_wr_size_out), 16'(sz[i]));
		end
		access(16'h3000, 1, MMD_SZ_WORD);
		check(flash_wr_out, 0);
		check(vacant_irq_out, 1);
		info_a_lock_in = 1;
		access(16'h1980, 1, MMD_SZ_WORD);
		check(flash_blocked_out, 1);
		check(flash_wr_out, 0);
		access(16'h1900, 1, MMD_SZ_BYTE);
		check(flash_wr_out, 1);
		erase(MMD_ER_SEG, 16'h1980, 0, 0);
		erase(MMD_ER_ALL, 16'h0000, 1, 0);
		info_a_lock_in = 0;
		access(16'h19FE, 1, MMD_SZ_WORD);
		check(flash_wr_out, 1);
	endtask
	task automatic test_erase();
		erase(MMD_ER_SEG, 16'h8200, 1, 0);
		erase(MMD_ER_MAIN, 16'h0000, 1, 0);
		erase(MMD_ER_ALL, 16'h0000, 1, 1);
		erase(MMD_ER_SEG, 16'h1880, 1, 0);
		erase(MMD_ER_SEG, 16'h1980, 1, 0);
		erase(MMD_ER_SEG, 16'h1200, 0, 0);
		erase(MMD_ER_NONE, 16'h8000, 0, 0);
	endtask
	task automatic test_ram();
		ram_enable_in = 2'h1;
		access(16'h2400, 0, MMD_SZ_WORD);
		check(ram_power_out, 2'h1);
		check(ram_sel_out, 2'h0);
		access(16'h1C00, 0, MMD_SZ_WORD);
		check(ram_sel_out, 2'h1);
		check(ram_retain_out, 2'h0);
		@(posedge core_clk_in);
		#1;
		check(ram_retain_out, 2'h1);
		ram_enable_in = 2'h2;
		access(16'h1C00, 0, MMD_SZ_WORD);
		check(ram_power_out, 2'h2);
		check(ram_sel_out, 2'h0);
		check(ram_retain_out, 2'h2);
		ram_enable_in = 2'h3;
	endtask
	// Clock enable low holds every output, then the held access is taken
	task automatic test_freeze();
		@(posedge core_clk_in);
		#1;
		acc_valid_in = 1;
		acc_write_in = 0;
		acc_addr_in = 16'h8000;
		@(posedge core_clk_in);
		#1;
		check(acc_done_out, 1);
		check(16'(region_out), 16'(MMD_MAIN));
		clk_en_in = 0;
		acc_addr_in = 16'h3000;
		@(posedge core_clk_in);
		#1;
		check(acc_done_out, 1);
		check(16'(region_out), 16'(MMD_MAIN));
		check(vacant_irq_out, 0);
		clk_en_in = 1;
		@(posedge core_clk_in);
		#1;
		acc_valid_in = 0;
		check(vacant_irq_out, 1);
		check(16'(region_out), 16'(MMD_VACANT));
		check(acc_rdata_out, 16'h3FFF);
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge core_clk_in);
		#1;
		check(16'(region_out), 16'(MMD_VACANT));
		check(ram_power_out, 2'h3);
		check(16'(erase_kind_out), 16'(MMD_ER_NONE));
		arst_n_in = 1;
		test_decode();
		test_writes();
		test_erase();
		test_ram();
		test_freeze();
		test_done();
	end
	initial begin
		#100000;
		bad_count++;
		test_done();
	end
endmodule
